// *** pmp_protect.sv ***
// pmp_protect: program memory with per-region code, write and table read protection
// assumes core table unit and external programmer share clk; erase sequencing lives outside
// Operation
// (R1) memory splits into a 2-Kbyte boot region and four binary-aligned regions
// (R2) each region has code, write and table read protect bits
// (R3) small layout bounds: 7FFh, 1FFFh, 3FFFh, 5FFFh, 7FFFh; absent space reads zero
// (R4) large layout bounds: 7FFh, 3FFFh, 7FFFh, BFFFh, FFFFh; 10000h up reads zero
// (R5) region code protect in 300008h bits 3:0, boot in 300009h bit 6
// (R6) write protect bits 3:0 at 30000Ah; boot bit 6, config bit 5 at 30000Bh
// (R7) table read protect bits 3:0 at 30000Ch; boot bit 6 at 30000Dh
// (R8) software keeps bits of absent regions at one
// (R9) table reads and writes reach all memory and the configuration bytes
// (R10) table reads return the device identification at its location
// (R11) code protect leaves core alone but blocks programmer reads and writes
// (R12) table read protect zero: reads from code inside the region succeed
// (R13) table read protect zero: reads from code outside return zeros
// (R14) writes only clear protection bits; writing one to zero bit does nothing
// (R15) only programmer-started chip or block erase sets protection bits again
// (R16) config write protect guards config bytes, read-only to the core
// (R17) table read protect one: reads return data from anywhere
// (R18) write protect zero: table writes leave the region unchanged
module pmp_protect
    import pmp_pkg::*;
#(
    parameter int MEM_BYTES = 65536,
    parameter int MEM_AW = 16,
    // arbitrary identification value
    parameter logic [15:0] DEV_ID = 16'h5A5A
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tbl_req,
    input wire logic tbl_write,
    input wire logic [21:0] tbl_addr,
    input wire logic [21:0] tbl_fetch_addr,
    input wire logic [7:0] tbl_wdata,
    output logic tbl_ready,
    output logic tbl_ack,
    output logic [7:0] tbl_rdata,
    input wire logic prg_req,
    input wire logic prg_write,
    input wire logic [21:0] prg_addr,
    input wire logic [7:0] prg_wdata,
    output logic prg_ack,
    output logic [7:0] prg_rdata,
    input wire logic prg_chip_erase,
    input wire logic prg_block_erase,
    input wire logic [2:0] prg_block_sel,
    output logic [4:0] region_code_protect,
    output logic [4:0] region_write_protect,
    output logic [4:0] region_ext_table_read_protect,
    output logic config_write_protect
);
    localparam bit BIG = (MEM_BYTES >= BIG_LAYOUT_BYTES);
    localparam logic [21:0] MEM_LIMIT = 22'(MEM_BYTES);

    // region lookup shared by target and fetch addresses
    function automatic pmp_region_t region_of(input logic [21:0] a);
        pmp_region_t r;
        r = PMP_NONE;
        if (a >= MEM_LIMIT) begin // (R3) (R4)
            r = PMP_NONE;
        end else if (a <= BOOT_END) begin // (R1)
            r = PMP_BOOT;
        end else if (a <= (BIG ? BIG_END0 : SML_END0)) begin
            r = PMP_REG0;
        end else if (a <= (BIG ? BIG_END1 : SML_END1)) begin
            r = PMP_REG1;
        end else if (a <= (BIG ? BIG_END2 : SML_END2)) begin
            r = PMP_REG2;
        end else if (a <= (BIG ? BIG_END3 : SML_END3)) begin
            r = PMP_REG3;
        end
        return r;
    endfunction

    // pick the protect bit of a region; boot is index 4
    function automatic logic prot_bit(input logic [4:0] v, input pmp_region_t r);
        logic b;
        b = 1'b0;
        if (r != PMP_NONE) begin
            b = v[r];
        end
        return b;
    endfunction

    logic [4:0] cp_reg;
    logic [4:0] wp_reg;
    logic [4:0] trp_reg;
    logic cfg_wp_reg;

    // access selection: the programmer wins the single memory port
    logic req;
    logic is_prg;
    logic is_write;
    logic [21:0] addr;
    logic [7:0] wdata;
    pmp_region_t tgt_region;
    pmp_region_t fetch_region;
    logic cfg_hit;
    logic id_hit;
    logic mem_allow;
    logic mem_wr;
    logic mem_rd;
    logic cfg_wr;
    logic [7:0] byte_val;
    pmp_src_t src;
    logic [7:0] mem_rdata;

    assign tbl_ready = ~prg_req;
    assign req = prg_req | tbl_req;
    assign is_prg = prg_req;
    assign is_write = is_prg ? prg_write : tbl_write;
    assign addr = is_prg ? prg_addr : tbl_addr;
    assign wdata = is_prg ? prg_wdata : tbl_wdata;
    assign tgt_region = region_of(addr);
    assign fetch_region = region_of(tbl_fetch_addr);
    assign cfg_hit = (addr >= CODE_PROTECT_LOW_ADDR) && (addr <= TABLE_READ_PROTECT_HIGH_ADDR);
    assign id_hit = (addr == DEV_ID_LOW_ADDR) || (addr == DEV_ID_HIGH_ADDR);

    always_comb begin
        mem_allow = 1'b0;
        if (tgt_region != PMP_NONE) begin
            if (is_prg) begin
                mem_allow = prot_bit(cp_reg, tgt_region); // (R11)
            end else if (is_write) begin
                mem_allow = prot_bit(wp_reg, tgt_region); // (R18)
            end else begin
                // (R12) (R13) (R17)
                mem_allow = prot_bit(trp_reg, tgt_region) || (fetch_region == tgt_region);
            end
        end
    end

    assign mem_wr = req && is_write && mem_allow; // (R9)
    assign mem_rd = req && !is_write && mem_allow; // (R9)
    // core writes to config bytes need the config write protect at one
    assign cfg_wr = req && is_write && cfg_hit && (is_prg || cfg_wp_reg); // (R16)

    // configuration and identification byte seen by reads
    always_comb begin
        byte_val = 8'h00;
        unique case (addr)
            CODE_PROTECT_LOW_ADDR: byte_val[3:0] = cp_reg[3:0]; // (R5)
            CODE_PROTECT_HIGH_ADDR: byte_val[BOOT_BIT] = cp_reg[4]; // (R5)
            WRITE_PROTECT_LOW_ADDR: byte_val[3:0] = wp_reg[3:0]; // (R6)
            WRITE_PROTECT_HIGH_ADDR: begin
                byte_val[BOOT_BIT] = wp_reg[4]; // (R6)
                byte_val[CFG_WP_BIT] = cfg_wp_reg; // (R6)
            end
            TABLE_READ_PROTECT_LOW_ADDR: byte_val[3:0] = trp_reg[3:0]; // (R7)
            TABLE_READ_PROTECT_HIGH_ADDR: byte_val[BOOT_BIT] = trp_reg[4]; // (R7)
            DEV_ID_LOW_ADDR: byte_val = DEV_ID[7:0]; // (R10)
            DEV_ID_HIGH_ADDR: byte_val = DEV_ID[15:8]; // (R10)
            default: byte_val = 8'h00;
        endcase
    end

    always_comb begin
        src = PMP_SRC_ZERO;
        if (cfg_hit || id_hit) begin
            src = PMP_SRC_BYTE;
        end else if (mem_rd) begin
            src = PMP_SRC_MEM;
        end
    end

    // next value of a protection group: clear-only writes, erase sets
    function automatic logic [4:0] prot_next(
        input logic [4:0] cur,
        input logic wr_lo,
        input logic wr_hi,
        input logic [7:0] d,
        input logic chip_erase,
        input logic blk_erase,
        input logic [2:0] blk
    );
        logic [4:0] n;
        n = cur;
        if (wr_lo) begin
            n[3:0] = cur[3:0] & d[REGION_BITS_LSB +: 4]; // (R14)
        end
        if (wr_hi) begin
            n[4] = cur[4] & d[BOOT_BIT]; // (R14)
        end
        // erase wins over a clearing write in the same cycle
        if (chip_erase) begin
            n = PROT_RESET; // (R15)
        end else if (blk_erase && blk <= 3'h4) begin
            n[blk] = 1'b1; // (R15)
        end
        return n;
    endfunction

    always_ff @(posedge clk) begin
        if (reset) begin
            cp_reg <= PROT_RESET;
        end else begin
            cp_reg <= prot_next(cp_reg, cfg_wr && addr == CODE_PROTECT_LOW_ADDR,
                cfg_wr && addr == CODE_PROTECT_HIGH_ADDR, wdata,
                prg_chip_erase, prg_block_erase, prg_block_sel); // (R2) (R5)
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wp_reg <= PROT_RESET;
        end else begin
            wp_reg <= prot_next(wp_reg, cfg_wr && addr == WRITE_PROTECT_LOW_ADDR,
                cfg_wr && addr == WRITE_PROTECT_HIGH_ADDR, wdata,
                prg_chip_erase, prg_block_erase, prg_block_sel); // (R2) (R6)
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trp_reg <= PROT_RESET;
        end else begin
            trp_reg <= prot_next(trp_reg, cfg_wr && addr == TABLE_READ_PROTECT_LOW_ADDR,
                cfg_wr && addr == TABLE_READ_PROTECT_HIGH_ADDR, wdata,
                prg_chip_erase, prg_block_erase, prg_block_sel); // (R2) (R7)
        end
    end

    // config write protect: only the programmer may clear it, only chip erase sets it
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_wp_reg <= CFG_WP_RESET;
        end else if (prg_chip_erase) begin
            cfg_wp_reg <= 1'b1; // (R15)
        end else if (cfg_wr && is_prg && addr == WRITE_PROTECT_HIGH_ADDR) begin
            cfg_wp_reg <= cfg_wp_reg & wdata[CFG_WP_BIT]; // (R14) (R16)
        end
    end

    pmp_mem #(
        .DEPTH(MEM_BYTES),
        .AW(MEM_AW)
    ) u_mem (
        .clk(clk),
        .wr_en(mem_wr),
        .rd_en(mem_rd),
        .addr(addr[MEM_AW-1:0]),
        .wdata(wdata),
        .rdata(mem_rdata)
    );

    // first stage: remember what the answer is made of
    logic s1_valid_reg;
    logic s1_prg_reg;
    pmp_src_t s1_src_reg;
    logic [7:0] s1_byte_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_valid_reg <= 1'b0;
            s1_prg_reg <= 1'b0;
            s1_src_reg <= PMP_SRC_ZERO;
            s1_byte_reg <= 8'h00;
        end else begin
            s1_valid_reg <= req;
            s1_prg_reg <= is_prg;
            s1_src_reg <= is_write ? PMP_SRC_ZERO : src;
            s1_byte_reg <= byte_val;
        end
    end

    // second stage: answer byte and acknowledge; refused reads give zeros
    logic [7:0] answer;
    always_comb begin
        unique case (s1_src_reg)
            PMP_SRC_MEM: answer = mem_rdata;
            PMP_SRC_BYTE: answer = s1_byte_reg;
            default: answer = 8'h00; // (R13)
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tbl_ack <= 1'b0;
            tbl_rdata <= 8'h00;
        end else begin
            tbl_ack <= s1_valid_reg && !s1_prg_reg;
            if (s1_valid_reg && !s1_prg_reg) begin
                tbl_rdata <= answer;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prg_ack <= 1'b0;
            prg_rdata <= 8'h00;
        end else begin
            prg_ack <= s1_valid_reg && s1_prg_reg;
            if (s1_valid_reg && s1_prg_reg) begin
                prg_rdata <= answer; // (R11)
            end
        end
    end

    assign region_code_protect = cp_reg;
    assign region_write_protect = wp_reg;
    assign region_ext_table_read_protect = trp_reg;
    assign config_write_protect = cfg_wp_reg;
endmodule

// *** pmp_pkg.sv ***
// pmp_pkg: constants for the program memory protection block
// assumes a 22-bit byte address space shared by table access and programmer
package pmp_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 8;

    // bottom region shared by both memory layouts
    localparam logic [21:0] BOOT_END = 22'h0007FF;
    // region upper bounds, 16/32-Kbyte layout
    localparam logic [21:0] SML_END0 = 22'h001FFF;
    localparam logic [21:0] SML_END1 = 22'h003FFF;
    localparam logic [21:0] SML_END2 = 22'h005FFF;
    localparam logic [21:0] SML_END3 = 22'h007FFF;
    // region upper bounds, 48/64-Kbyte layout
    localparam logic [21:0] BIG_END0 = 22'h003FFF;
    localparam logic [21:0] BIG_END1 = 22'h007FFF;
    localparam logic [21:0] BIG_END2 = 22'h00BFFF;
    localparam logic [21:0] BIG_END3 = 22'h00FFFF;
    // sizes at or above this use the larger layout
    localparam int BIG_LAYOUT_BYTES = 49152;

    // configuration byte addresses
    localparam logic [21:0] CODE_PROTECT_LOW_ADDR = 22'h300008;
    localparam logic [21:0] CODE_PROTECT_HIGH_ADDR = 22'h300009;
    localparam logic [21:0] WRITE_PROTECT_LOW_ADDR = 22'h30000A;
    localparam logic [21:0] WRITE_PROTECT_HIGH_ADDR = 22'h30000B;
    localparam logic [21:0] TABLE_READ_PROTECT_LOW_ADDR = 22'h30000C;
    localparam logic [21:0] TABLE_READ_PROTECT_HIGH_ADDR = 22'h30000D;
    // device identification, low and high byte
    localparam logic [21:0] DEV_ID_LOW_ADDR = 22'h3FFFFE;
    localparam logic [21:0] DEV_ID_HIGH_ADDR = 22'h3FFFFF;

    // field positions inside the configuration bytes
    localparam int REGION_BITS_LSB = 0;
    localparam int BOOT_BIT = 6;
    localparam int CFG_WP_BIT = 5;

    // erased state: every protection bit at one
    localparam logic [4:0] PROT_RESET = 5'h1F;
    localparam logic CFG_WP_RESET = 1'b1;

    // region index: 0..3 numbered regions, 4 boot, 7 outside memory
    typedef enum logic [2:0] {
        PMP_REG0 = 3'b000,
        PMP_REG1 = 3'b001,
        PMP_REG2 = 3'b010,
        PMP_REG3 = 3'b011,
        PMP_BOOT = 3'b100,
        PMP_NONE = 3'b111
    } pmp_region_t;

    // source of the answer byte
    typedef enum logic [1:0] {
        PMP_SRC_ZERO = 2'b00,
        PMP_SRC_MEM = 2'b01,
        PMP_SRC_BYTE = 2'b10
    } pmp_src_t;
endpackage

// *** pmp_mem.sv ***
// pmp_mem: byte-wide program memory array with registered read data
// assumes one access per cycle; arbitration is done by the caller
module pmp_mem #(
    parameter int DEPTH = 65536,
    parameter int AW = 16
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem_array [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_array[addr] <= wdata;
        end
    end

    // read data is held between reads
    always_ff @(posedge clk) begin
        if (rd_en) begin
            rdata <= mem_array[addr];
        end
    end
endmodule

// *** pmp_protect_sva.sv ***
// pmp_protect_sva: port checks for the protection block
// assumes the 64-Kbyte layout and an answer two edges after the taking edge
module pmp_protect_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic tbl_req,
    input wire logic tbl_write,
    input wire logic [21:0] tbl_addr,
    input wire logic [21:0] tbl_fetch_addr,
    input wire logic [7:0] tbl_wdata,
    input wire logic tbl_ready,
    input wire logic tbl_ack,
    input wire logic [7:0] tbl_rdata,
    input wire logic prg_req,
    input wire logic prg_write,
    input wire logic prg_ack,
    input wire logic prg_chip_erase,
    input wire logic prg_block_erase,
    input wire logic [4:0] region_code_protect,
    input wire logic [4:0] region_write_protect,
    input wire logic [4:0] region_ext_table_read_protect,
    input wire logic config_write_protect
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // programmer wins, so a core request counts only without one
    wire logic tk = tbl_req && !prg_req;
    wire logic rd = tk && !tbl_write;
    wire logic [15:0] pv = {region_code_protect, region_write_protect,
        region_ext_table_read_protect, config_write_protect};
    core_answer_a:
        assert property (tk |-> ##2 tbl_ack) else $error("core answer missing");
    prog_answer_a:
        assert property (prg_req |-> ##2 prg_ack) else $error("programmer answer missing");
    ack_cause_a:
        assert property (tbl_ack |-> $past(tk, 2)) else $error("core answer without request");
    core_yield_a:
        assert property (prg_req |-> !tbl_ready) else $error("core not held off");
    erase_all_a:
        assert property (prg_chip_erase |=> pv == 16'hFFFF) else $error("chip erase incomplete");
    raise_erase_a:
        assert property (|(pv & ~$past(pv)) |-> $past(prg_chip_erase || prg_block_erase))
        else $error("protect bit set without erase");
    cfg_lock_a:
        assert property ($fell(config_write_protect) |-> $past(prg_req && prg_write))
        else $error("config lock cleared by core");
    wp_clear_a:
        assert property (tk && tbl_write && tbl_addr == 22'h30000A && config_write_protect
            && !prg_chip_erase && !prg_block_erase |=> region_write_protect[3:0]
            == $past(region_write_protect[3:0] & tbl_wdata[3:0])) else $error("bad clear");
    unmapped_zero_a:
        assert property (rd && tbl_addr >= 22'h010000 && tbl_addr < 22'h300000
            |-> ##2 tbl_rdata == 8'h00) else $error("unmapped read not zero");
    trp_refuse_a:
        assert property (rd && tbl_addr[21:14] == 8'h01 && tbl_fetch_addr[21:14] != 8'h01
            && !region_ext_table_read_protect[1] |-> ##2 tbl_rdata == 8'h00)
        else $error("foreign table read not refused");
endmodule

bind pmp_protect pmp_protect_sva pmp_protect_sva_inst (.*);

// *** pmp_prog_model.sv ***
// pmp_prog_model: external programmer on the programming port
// assumes each request is taken at the next edge
module pmp_prog_model (
    input wire logic clk,
    output logic prg_req,
    output logic prg_write,
    output logic [21:0] prg_addr,
    output logic [7:0] prg_wdata,
    input wire logic prg_ack,
    input wire logic [7:0] prg_rdata,
    output logic prg_chip_erase,
    output logic prg_block_erase,
    output logic [2:0] prg_block_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {prg_req, prg_write, prg_chip_erase, prg_block_erase} = 4'h0;
        {prg_addr, prg_wdata, prg_block_sel} = 33'h0;
    end
    // released lines show the inverse so a stale value never passes
    task automatic acc(input logic w, input logic [21:0] a, input logic [7:0] d,
            output logic [7:0] q);
        int k;
        prg_req <= 1'b1;
        prg_write <= w;
        prg_addr <= a;
        prg_wdata <= d;
        @(posedge clk);
        prg_req <= 1'b0;
        prg_addr <= ~a;
        prg_wdata <= ~d;
        for (k = 0; k < 4 && prg_ack !== 1'b1; k++) @(posedge clk);
        q = prg_rdata;
    endtask
    task automatic erase(input logic chip, input logic [2:0] sel);
        prg_chip_erase <= chip;
        prg_block_erase <= !chip;
        prg_block_sel <= sel;
        @(posedge clk);
        {prg_chip_erase, prg_block_erase} <= 2'h0;
        prg_block_sel <= ~sel;
        @(posedge clk);
    endtask
endmodule

// *** pmp_protect_tb.sv ***
// pmp_protect_tb: random and corner tests of the protection block
// assumes the 64-Kbyte layout and the programmer model beside it
module pmp_protect_tb
    import pmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] ID = 16'hC35A; // arbitrary identification value
    logic clk = 1'b0, reset = 1'b1, tbl_req = 1'b0, tbl_write = 1'b0, tbl_ready, tbl_ack;
    logic [21:0] tbl_addr = 22'h0, tbl_fetch_addr = 22'h0, prg_addr;
    logic [7:0] tbl_wdata = 8'h00, tbl_rdata, prg_wdata, prg_rdata, q, d;
    logic prg_req, prg_write, prg_ack, prg_chip_erase, prg_block_erase, config_write_protect;
    logic [2:0] prg_block_sel;
    logic [4:0] region_code_protect, region_write_protect, region_ext_table_read_protect;
    logic [4:0] pr [3];
    logic cw;
    logic [21:0] ad [5];
    logic [7:0] md [5];
    int n_errors = 0, check_count = 0, seed, j;
    // full-size memory: every region exists, so random clears never touch an absent one
    pmp_protect #(.DEV_ID(ID)) pmp_protect_inst (.*);
    pmp_prog_model pmp_prog_model_inst (.*);
    always #50 clk = ~clk;
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, s, e);
        end
    endtask
    // core table access; held until the port is free
    task automatic ct(input logic w, input logic [21:0] a, input logic [21:0] f,
            input logic [7:0] wd);
        int k;
        tbl_req <= 1'b1;
        tbl_write <= w;
        tbl_addr <= a;
        tbl_fetch_addr <= f;
        tbl_wdata <= wd;
        @(posedge clk);
        while (tbl_ready !== 1'b1) @(posedge clk);
        tbl_req <= 1'b0;
        tbl_addr <= ~a;
        for (k = 0; k < 4 && tbl_ack !== 1'b1; k++) @(posedge clk);
        chk({7'h0, tbl_ack}, 8'h01);
        q = tbl_rdata;
    endtask
    function automatic logic [7:0] ex(input int i);
        if (i % 2 == 0) return {4'h0, pr[i / 2][3:0]};
        return {1'b0, pr[i / 2][4], (i == 3) ? cw : 1'b0, 5'h00};
    endfunction
    task automatic chk_out();
        chk({3'h0, region_code_protect}, {3'h0, pr[0]});
        chk({3'h0, region_write_protect}, {3'h0, pr[1]});
        chk({3'h0, region_ext_table_read_protect}, {3'h0, pr[2]});
        chk({7'h0, config_write_protect}, {7'h0, cw});
    endtask
    task automatic cfg_pass(input logic [7:0] m);
        int i;
        for (i = 0; i < 6; i++) begin
            d = 8'($urandom) | m;
            ct(1'b1, CODE_PROTECT_LOW_ADDR + 22'(i), 22'h0, d);
            if (i % 2 == 0) pr[i / 2][3:0] &= d[3:0];
            else pr[i / 2][4] &= d[6];
        end
        for (i = 0; i < 6; i++) begin
            ct(1'b0, CODE_PROTECT_LOW_ADDR + 22'(i), 22'h0, 8'h00);
            chk(q, ex(i));
        end
        chk_out();
    endtask
    // 0 foreign fetch, 1 foreign refused, 2 own fetch, 3 programmer refused, 4 programmer read
    task automatic sweep(input int mode);
        int k;
        for (k = 0; k < 5; k++) begin
            if (mode >= 3) pmp_prog_model_inst.acc(1'b0, ad[k], 8'h00, q);
            else ct(1'b0, ad[k], ad[(mode == 2) ? k : (k + 1) % 5], 8'h00);
            chk(q, (mode % 2 == 1) ? 8'h00 : md[k]);
            if (mode >= 3) chk({7'h0, prg_ack}, 8'h01);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        seed = $urandom(79186);
        pr = '{default: 5'h1F};
        cw = 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        chk_out();
        cfg_pass(8'h00);
        cfg_pass(8'hFF);
        $display("test config bytes done");
        pmp_prog_model_inst.erase(1'b1, 3'h0);
        pr = '{default: 5'h1F};
        ct(1'b1, CODE_PROTECT_LOW_ADDR, 22'h0, 8'h00);
        pr[0][3:0] = 4'h0;
        pmp_prog_model_inst.erase(1'b0, 3'h2);
        pmp_prog_model_inst.erase(1'b0, 3'h5);
        pr[0][2] = 1'b1;
        chk_out();
        $display("test erase done");
        pmp_prog_model_inst.erase(1'b1, 3'h0);
        ad = '{22'h0007FF, 22'h000800, 22'h004000 + 22'($urandom_range(16383)),
            22'h00BFFF, 22'h00C000};
        for (j = 0; j < 5; j++) begin
            md[j] = 8'($urandom);
            pmp_prog_model_inst.acc(1'b1, ad[j], md[j], q);
        end
        sweep(0);
        sweep(4);
        ct(1'b1, TABLE_READ_PROTECT_LOW_ADDR, 22'h0, 8'h00);
        ct(1'b1, TABLE_READ_PROTECT_HIGH_ADDR, 22'h0, 8'h00);
        sweep(1);
        sweep(2);
        ct(1'b1, WRITE_PROTECT_LOW_ADDR, 22'h0, 8'h00);
        ct(1'b1, WRITE_PROTECT_HIGH_ADDR, 22'h0, 8'h00);
        for (j = 0; j < 5; j++) ct(1'b1, ad[j], ad[j], ~md[j]);
        sweep(2);
        ct(1'b1, CODE_PROTECT_LOW_ADDR, 22'h0, 8'h00);
        ct(1'b1, CODE_PROTECT_HIGH_ADDR, 22'h0, 8'h00);
        sweep(3);
        sweep(2);
        $display("test region access done");
        ct(1'b0, 22'h010000 + 22'($urandom_range(65535)), 22'h0, 8'h00);
        chk(q, 8'h00);
        ct(1'b0, DEV_ID_LOW_ADDR, 22'h0, 8'h00);
        chk(q, ID[7:0]);
        ct(1'b0, DEV_ID_HIGH_ADDR, 22'h0, 8'h00);
        chk(q, ID[15:8]);
        pmp_prog_model_inst.erase(1'b1, 3'h0);
        pmp_prog_model_inst.acc(1'b1, WRITE_PROTECT_HIGH_ADDR, 8'hDF, q);
        ct(1'b1, CODE_PROTECT_LOW_ADDR, 22'h0, 8'h00);
        pr = '{default: 5'h1F};
        cw = 1'b0;
        chk_out();
        $display("test config lock done");
        give_verdict();
    end
endmodule
